//--- src/rcbm_consts.vh
`ifndef RCBM_CONSTS_VH
`define RCBM_CONSTS_VH

// ==============================================
// Reset timing in CPU clock cycles
// ==============================================
`define RCBM_QUAL_CYC 8
`define RCBM_STRETCH_CYC 1024
`define RCBM_QUAL_W 4
`define RCBM_STRETCH_W 11

// ==============================================
// Register byte offsets on the Wishbone slave
// ==============================================
`define RCBM_ADR_W 8
`define RCBM_OFF_CTRL 8'h00
`define RCBM_OFF_CAUSE 8'h04
`define RCBM_OFF_EVENT 8'h08
`define RCBM_OFF_MASK 8'h0C
`define RCBM_OFF_BOOT 8'h10

// ==============================================
// Field positions
// ==============================================
`define RCBM_CTRL_SWRST 0
`define RCBM_SRC_POR 0
`define RCBM_SRC_EXT 1
`define RCBM_SRC_SW 2
`define RCBM_SRC_WDOG 3
`define RCBM_SRC_LOC 4
`define RCBM_SRC_LOL 5
`define RCBM_SRC_LVD 6
`define RCBM_NSRC 7
`define RCBM_EV_DONE 7
`define RCBM_NEV 8
`define RCBM_BOOT_SEL_LO 0
`define RCBM_BOOT_STRAP 2
`define RCBM_BOOT_SRC_LO 3
`define RCBM_BOOT_PLL 5
`define RCBM_BOOT_FLASH 6

// ==============================================
// Reset values and encodings
// ==============================================
`define RCBM_CAUSE_RST 7'h01
`define RCBM_EVENT_RST 8'h00
`define RCBM_MASK_RST 8'h00
`define RCBM_SRC_EXTOSC 2'h0
`define RCBM_SRC_ONCHIP 2'h1
`define RCBM_SRC_CRYSTAL 2'h2
`define RCBM_SEL_RST 2'h0
`define RCBM_PINS_W 9

`endif

//--- src/rcbm_sync.v
// ==============================================
// Two-stage synchroniser for a bundle of pins
// ==============================================
module rcbm_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);

   reg [W-1:0] meta;

   // The first stage is read by the second stage only.
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else if (ce_i) begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule // rcbm_sync

//--- src/rcbm_reset_boot.v
// Design decisions made here: the register addresses and the Wishbone register port.
`include "rcbm_consts.vh"

// What this block does
// R1 - Reset pin must stay low 8 cycles
// R2 - Reset output low 1024 cycles after release
// R3 - Mode pins and strap select clock, PLL
// R4 - Mode 00: no PLL, external oscillator, strap ignored
// R5 - Mode 01: no PLL, crystal clock
// R6 - Mode 10: PLL on, strap picks reference
// R7 - Mode 11: PLL on, crystal reference
// R8 - Upper mode bit turns crystal pin input
// R9 - Clock pin unused with on-chip oscillator
// R10 - Config strap, no test: flash programming
// R11 - Clock output copies selected system clock
// R12 - Seven reset sources, last cause recorded
// R13 - Straps sampled at release, then held; crystal pin direction tracks live upper mode bit
// R14 - Stretch starts once all sources released
module rcbm_reset_boot #(
   parameter QUAL_CYCLES = `RCBM_QUAL_CYC,
   parameter STRETCH_CYCLES = `RCBM_STRETCH_CYC
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`RCBM_ADR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire reset_in_n_i,
   output wire reset_out_n_o,
   output wire chip_reset_o,
   input wire watchdog_reset_i,
   input wire loss_of_clock_i,
   input wire loss_of_lock_i,
   input wire low_voltage_detect_i,
   input wire [1:0] clock_boot_select_i,
   input wire osc_out_strap_i,
   output reg osc_out_strap_o,
   output reg osc_out_strap_oe_o,
   input wire osc_clock_in_i,
   input wire relax_osc_i,
   input wire pll_clock_i,
   output reg osc_in_enable_o,
   output reg pll_enable_o,
   output reg [1:0] clock_source_o,
   output reg system_clock_out_o,
   input wire boot_config_strap_n_i,
   input wire test_i,
   output reg serial_flash_prog_o,
   output wire irq_o
);

   // ==============================================
   // Decode of the clock boot mode
   // ==============================================

   // Returns {pll enable, clock source} for a mode code and strap level.
   function [2:0] rcbm_clk_decode;
      input [1:0] sel;
      input strap;
      begin
         case (sel)
            // R4 mode 00 decode
            2'h0: rcbm_clk_decode = {1'b0, strap ? `RCBM_SRC_ONCHIP : `RCBM_SRC_EXTOSC};
            // R5 mode 01 decode
            2'h1: rcbm_clk_decode = {1'b0, `RCBM_SRC_CRYSTAL};
            // R6 mode 10 decode
            2'h2: rcbm_clk_decode = {1'b1, strap ? `RCBM_SRC_ONCHIP : `RCBM_SRC_EXTOSC};
            // R7 mode 11 decode
            2'h3: rcbm_clk_decode = {1'b1, `RCBM_SRC_CRYSTAL};
            default: rcbm_clk_decode = {1'b0, `RCBM_SRC_EXTOSC};
         endcase
      end
   endfunction

   // ==============================================
   // Pin synchronisers
   // ==============================================
   wire [`RCBM_PINS_W-1:0] pins_raw;
   wire [`RCBM_PINS_W-1:0] pins_s;
   wire rst_pin_n_s;
   wire [1:0] sel_s;
   wire strap_s;
   wire cfg_n_s;
   wire test_s;
   wire osc_in_s;
   wire relax_s;
   wire pll_s;

   assign pins_raw = {pll_clock_i, relax_osc_i, osc_clock_in_i, test_i, boot_config_strap_n_i,
                      osc_out_strap_i, clock_boot_select_i, reset_in_n_i};

   rcbm_sync #(
      .W(`RCBM_PINS_W),
      .RST_VAL(9'h009)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   assign rst_pin_n_s = pins_s[0];
   assign sel_s = pins_s[2:1];
   assign strap_s = pins_s[3];
   assign cfg_n_s = pins_s[4];
   assign test_s = pins_s[5];
   assign osc_in_s = pins_s[6];
   assign relax_s = pins_s[7];
   assign pll_s = pins_s[8];

   // ==============================================
   // External reset qualification
   // ==============================================
   reg [`RCBM_QUAL_W-1:0] qual_cnt;
   reg ext_req;
   reg por_req;
   reg sw_req;

   // R1 qualify pin low
   always @(posedge clk_i) begin
      if (rst_i) begin
         qual_cnt <= {`RCBM_QUAL_W{1'b0}};
         ext_req <= 1'b0;
      end else if (ce_i) begin
         if (rst_pin_n_s) begin
            qual_cnt <= {`RCBM_QUAL_W{1'b0}};
            ext_req <= 1'b0;
         end else if (qual_cnt == QUAL_CYCLES[`RCBM_QUAL_W-1:0] - 1'b1) begin
            ext_req <= 1'b1;
         end else begin
            qual_cnt <= qual_cnt + 1'b1;
         end
      end
   end

   // Power-on request stands for the first cycle after the block reset.
   always @(posedge clk_i) begin
      if (rst_i) begin
         por_req <= 1'b1;
      end else if (ce_i) begin
         por_req <= 1'b0;
      end
   end

   // ==============================================
   // Reset sources and stretch
   // ==============================================
   wire [`RCBM_NSRC-1:0] src_act;
   wire any_src;
   reg [`RCBM_NSRC-1:0] src_prev;
   reg [`RCBM_STRETCH_W-1:0] stretch_cnt;
   reg in_reset;
   reg [`RCBM_NSRC-1:0] cause;
   wire stretch_done;

   // R12 seven reset sources
   assign src_act = {low_voltage_detect_i, loss_of_lock_i, loss_of_clock_i, watchdog_reset_i,
                     sw_req, ext_req, por_req};
   assign any_src = |src_act;

   // R14 hold while active
   always @(posedge clk_i) begin
      if (rst_i) begin
         in_reset <= 1'b1;
         stretch_cnt <= {`RCBM_STRETCH_W{1'b0}};
      end else if (ce_i) begin
         if (any_src) begin
            in_reset <= 1'b1;
            stretch_cnt <= {`RCBM_STRETCH_W{1'b0}};
         end else if (in_reset) begin
            // R2 stretch after release
            if (stretch_cnt == STRETCH_CYCLES[`RCBM_STRETCH_W-1:0] - 1'b1) begin
               in_reset <= 1'b0;
            end else begin
               stretch_cnt <= stretch_cnt + 1'b1;
            end
         end
      end
   end

   assign stretch_done = ce_i & in_reset & ~any_src &
                         (stretch_cnt == STRETCH_CYCLES[`RCBM_STRETCH_W-1:0] - 1'b1);

   // R1 immediate core reset
   assign chip_reset_o = in_reset | any_src;
   // R2 drive reset output
   assign reset_out_n_o = ~chip_reset_o;

   // R12 record last cause
   always @(posedge clk_i) begin
      if (rst_i) begin
         cause <= `RCBM_CAUSE_RST;
         src_prev <= {`RCBM_NSRC{1'b0}};
      end else if (ce_i) begin
         src_prev <= src_act;
         if (any_src) begin
            if (in_reset && (stretch_cnt == {`RCBM_STRETCH_W{1'b0}})) begin
               cause <= cause | src_act;
            end else begin
               cause <= src_act;
            end
         end
      end
   end

   // ==============================================
   // Boot straps and clock selection
   // ==============================================
   reg [1:0] sel_lat;
   reg strap_lat;
   wire [2:0] clk_dec;

   assign clk_dec = rcbm_clk_decode(sel_lat, strap_lat);

   // R13 sample at release
   always @(posedge clk_i) begin
      if (rst_i) begin
         sel_lat <= `RCBM_SEL_RST;
         strap_lat <= 1'b0;
         serial_flash_prog_o <= 1'b0;
      end else if (stretch_done) begin
         sel_lat <= sel_s;
         // R8 strap only when upper bit set
         strap_lat <= sel_s[1] & strap_s;
         // R10 flash programming entry
         serial_flash_prog_o <= ~cfg_n_s & ~test_s;
      end
   end

   // R3 apply decoded mode
   always @(posedge clk_i) begin
      if (rst_i) begin
         pll_enable_o <= 1'b0;
         clock_source_o <= `RCBM_SRC_EXTOSC;
         osc_in_enable_o <= 1'b1;
      end else if (ce_i) begin
         pll_enable_o <= clk_dec[2];
         clock_source_o <= clk_dec[1:0];
         // R9 clock pin use
         osc_in_enable_o <= (clk_dec[1:0] != `RCBM_SRC_ONCHIP);
      end
   end

   // R8 crystal pin direction
   always @(posedge clk_i) begin
      if (rst_i) begin
         osc_out_strap_o <= 1'b0;
         osc_out_strap_oe_o <= 1'b0;
      end else if (ce_i) begin
         osc_out_strap_oe_o <= ~sel_s[1];
         osc_out_strap_o <= ~osc_in_s;
      end
   end

   // R11 clock output copy
   always @(posedge clk_i) begin
      if (rst_i) begin
         system_clock_out_o <= 1'b0;
      end else if (ce_i) begin
         if (clk_dec[2]) begin
            system_clock_out_o <= pll_s;
         end else if (clk_dec[1:0] == `RCBM_SRC_ONCHIP) begin
            system_clock_out_o <= relax_s;
         end else begin
            system_clock_out_o <= osc_in_s;
         end
      end
   end

   // ==============================================
   // Wishbone slave and interrupt registers
   // ==============================================
   reg [`RCBM_NEV-1:0] event_st;
   reg [`RCBM_NEV-1:0] event_mask;
   wire [`RCBM_NEV-1:0] event_set;
   wire req;
   wire wr;
   reg [31:0] next_rdata;

   assign req = wb_cyc_i & wb_stb_i;
   assign wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign event_set = {stretch_done, src_act & ~src_prev};
   assign irq_o = |(event_st & event_mask);

   // Ack follows a request by one cycle and drops the cycle after.
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= next_rdata;
      end
   end

   // Read mux; unmapped offsets read as zero.
   always @* begin
      next_rdata = 32'h00000000;
      case (wb_adr_i)
         `RCBM_OFF_CAUSE: next_rdata[`RCBM_NSRC-1:0] = cause;
         `RCBM_OFF_EVENT: next_rdata[`RCBM_NEV-1:0] = event_st;
         `RCBM_OFF_MASK: next_rdata[`RCBM_NEV-1:0] = event_mask;
         `RCBM_OFF_BOOT: begin
            next_rdata[`RCBM_BOOT_SEL_LO+1:`RCBM_BOOT_SEL_LO] = sel_lat;
            next_rdata[`RCBM_BOOT_STRAP] = strap_lat;
            next_rdata[`RCBM_BOOT_SRC_LO+1:`RCBM_BOOT_SRC_LO] = clk_dec[1:0];
            next_rdata[`RCBM_BOOT_PLL] = clk_dec[2];
            next_rdata[`RCBM_BOOT_FLASH] = serial_flash_prog_o;
         end
         default: next_rdata = 32'h00000000;
      endcase
   end

   // R12 software reset source
   always @(posedge clk_i) begin
      if (rst_i) begin
         sw_req <= 1'b0;
      end else if (ce_i) begin
         sw_req <= wr & (wb_adr_i == `RCBM_OFF_CTRL) & wb_dat_i[`RCBM_CTRL_SWRST];
      end
   end

   // Sticky events: write one clears, a new event wins over the clear.
   always @(posedge clk_i) begin
      if (rst_i) begin
         event_st <= `RCBM_EVENT_RST;
         event_mask <= `RCBM_MASK_RST;
      end else if (ce_i) begin
         if (wr && (wb_adr_i == `RCBM_OFF_EVENT)) begin
            event_st <= (event_st & ~wb_dat_i[`RCBM_NEV-1:0]) | event_set;
         end else begin
            event_st <= event_st | event_set;
         end
         if (wr && (wb_adr_i == `RCBM_OFF_MASK)) begin
            event_mask <= wb_dat_i[`RCBM_NEV-1:0];
         end
      end
   end

endmodule // rcbm_reset_boot

//--- testbench/rcbm_reset_boot_assertions.sv
// ==============================================
// Port checker for the reset and boot block
// ==============================================
module rcbm_reset_boot_assertions #(
   parameter QUAL_CYCLES = 8,
   parameter STRETCH_CYCLES = 1024
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire reset_in_n_i,
   input wire reset_out_n_o,
   input wire chip_reset_o,
   input wire watchdog_reset_i,
   input wire loss_of_clock_i,
   input wire loss_of_lock_i,
   input wire low_voltage_detect_i,
   input wire pll_enable_o,
   input wire [1:0] clock_source_o,
   input wire osc_in_enable_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [11:0] quiet;
   wire int_src = watchdog_reset_i | loss_of_clock_i | loss_of_lock_i | low_voltage_detect_i;
   // Counts held-reset cycles once the reset pin and the four internal sources have gone quiet.
   always @(posedge clk_i) begin
      if (rst_i || reset_out_n_o || int_src || !reset_in_n_i)
         quiet <= 12'h000;
      else if (ce_i && quiet != 12'hFFF)
         quiet <= quiet + 12'h001;
   end
   sequence s_pin_low;
      (!reset_in_n_i) [*8];
   endsequence
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_ack_resp;
      ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   property p_chip;
      chip_reset_o == !reset_out_n_o;
   endproperty
   property p_src_hold;
      int_src |-> !reset_out_n_o;
   endproperty
   property p_str_min;
      $rose(reset_out_n_o) |-> quiet >= STRETCH_CYCLES - 1;
   endproperty
   property p_str_max;
      !reset_out_n_o |-> quiet <= STRETCH_CYCLES + 6;
   endproperty
   property p_pin_qual;
      s_pin_low |-> ##[0:5] !reset_out_n_o;
   endproperty
   property p_boot_hold;
      reset_out_n_o && $past(reset_out_n_o) && $past(reset_out_n_o, 2)
         |-> $stable(pll_enable_o) && $stable(clock_source_o);
   endproperty
   property p_osc_en;
      osc_in_enable_o == (clock_source_o != 2'h1);
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
   a_chip: assert property (p_chip) else $error("core reset mismatch");
   a_src_hold: assert property (p_src_hold) else $error("reset out released early");
   a_str_min: assert property (p_str_min) else $error("stretch too short");
   a_str_max: assert property (p_str_max) else $error("stretch too long");
   a_pin_qual: assert property (p_pin_qual) else $error("pin reset not taken");
   a_boot_hold: assert property (p_boot_hold) else $error("boot clock changed");
   a_osc_en: assert property (p_osc_en) else $error("osc input enable wrong");
endmodule // rcbm_reset_boot_assertions

bind rcbm_reset_boot rcbm_reset_boot_assertions #(.QUAL_CYCLES(QUAL_CYCLES), .STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
   .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .reset_in_n_i, .reset_out_n_o, .chip_reset_o,
   .watchdog_reset_i, .loss_of_clock_i, .loss_of_lock_i, .low_voltage_detect_i, .pll_enable_o,
   .clock_source_o, .osc_in_enable_o);

//--- testbench/rcbm_board_model.sv
// ==============================================
// Board side: reset button, straps, clock sources
// ==============================================
module rcbm_board_model (
   input wire clk_i,
   input wire [4:0] cfg_i,
   input wire [4:0] pulse_i,
   input wire oe_i,
   input wire drv_i,
   output wire reset_in_n_o,
   output wire [1:0] sel_o,
   output wire pin_o,
   output wire cfg_n_o,
   output wire test_o,
   output wire [2:0] clks_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt = 5'h00;
   logic [2:0] ph = 3'h0;
   // Free-running oscillator levels.
   always @(posedge clk_i) begin
      ph <= ph + 3'h1;
   end
   assign clks_o = ph;
   always @(posedge clk_i) begin
      if (pulse_i != 5'h00)
         cnt <= pulse_i;
      else if (cnt != 5'h00)
         cnt <= cnt - 5'h01;
   end
   assign reset_in_n_o = (cnt == 5'h00);
   assign pin_o = oe_i ? drv_i : cfg_i[2];
   assign sel_o = cfg_i[1:0];
   assign cfg_n_o = cfg_i[3];
   assign test_o = cfg_i[4];
endmodule // rcbm_board_model

//--- testbench/rcbm_reset_boot_tb.sv
module rcbm_reset_boot_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, reset_out_n_o, chip_reset_o, osc_out_strap_o, osc_out_strap_oe_o, osc_in_enable_o;
   logic pll_enable_o, system_clock_out_o, serial_flash_prog_o, irq_o;
   logic [1:0] clock_source_o;
   logic watchdog_reset_i = 0, loss_of_clock_i = 0, loss_of_lock_i = 0, low_voltage_detect_i = 0;
   wire reset_in_n_i, osc_out_strap_i, osc_clock_in_i, relax_osc_i, pll_clock_i, boot_config_strap_n_i, test_i;
   wire [1:0] clock_boot_select_i;
   logic [4:0] cfg = 5'h08, pulse = 5'h00;
   logic [15:0] tbl [8] = '{16'h0800, 16'h0D11, 16'h0A22, 16'h0E2E, 16'h0B33, 16'h0F37, 16'h0040, 16'h1111};
   int n_fail = 0, cmp_count = 0;
   // Free-running system clock.
   always #5 clk_i = ~clk_i;
   rcbm_reset_boot #(.STRETCH_CYCLES(16)) dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_in_n_i, .reset_out_n_o, .chip_reset_o, .watchdog_reset_i,
      .loss_of_clock_i, .loss_of_lock_i, .low_voltage_detect_i, .clock_boot_select_i, .osc_out_strap_i,
      .osc_out_strap_o, .osc_out_strap_oe_o, .osc_clock_in_i, .relax_osc_i, .pll_clock_i, .osc_in_enable_o,
      .pll_enable_o, .clock_source_o, .system_clock_out_o, .boot_config_strap_n_i, .test_i,
      .serial_flash_prog_o, .irq_o);
   rcbm_board_model brd (.clk_i, .cfg_i(cfg), .pulse_i(pulse), .oe_i(osc_out_strap_oe_o),
      .drv_i(osc_out_strap_o), .reset_in_n_o(reset_in_n_i), .sel_o(clock_boot_select_i),
      .pin_o(osc_out_strap_i), .cfg_n_o(boot_config_strap_n_i), .test_o(test_i),
      .clks_o({pll_clock_i, relax_osc_i, osc_clock_in_i}));
   task automatic test_done;
      if (n_fail == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Single classic bus cycle, held until ack is sampled.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      chk(n < 50, 1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // Waits for reset out to fall, then to rise again.
   task automatic wrel;
      int n;
      n = 0;
      while (reset_out_n_o !== 1'b0 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      chk(n < 40, 1);
      n = 0;
      while (reset_out_n_o !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      repeat (3) @(posedge clk_i);
      chk(reset_out_n_o, 1);
   endtask
   task automatic t_por;
      wrel;
      rd(8'h04, 32'h01);
      rd(8'h0C, 32'h00);
      wb_sel_i <= 4'hE;
      wb(1'b1, 8'h0C, 32'hFF);
      wb_sel_i <= 4'hF;
      rd(8'h0C, 32'h00);
      wb(1'b1, 8'h40, 32'hFF);
      rd(8'h40, 32'h00);
   endtask
   task automatic t_pin;
      int lows;
      lows = 0;
      pulse <= 5'h07;
      @(posedge clk_i);
      pulse <= 5'h00;
      repeat (25) begin
         @(posedge clk_i);
         lows += !reset_out_n_o;
      end
      chk(lows, 0);
      pulse <= 5'h08;
      @(posedge clk_i);
      pulse <= 5'h00;
      wrel;
      rd(8'h04, 32'h02);
   endtask
   task automatic t_modes;
      for (int i = 0; i < 8; i++) begin
         cfg <= tbl[i][12:8];
         wb(1'b1, 8'h00, 32'h01);
         wrel;
         rd(8'h10, tbl[i][6:0]);
         rd(8'h04, 32'h04);
         chk({pll_enable_o, clock_source_o}, tbl[i][5:3]);
         chk(serial_flash_prog_o, tbl[i][6]);
         chk(osc_out_strap_oe_o, !tbl[i][9]);
         t_clk(tbl[i][5] ? 4 : (tbl[i][4:3] == 2'h1 ? 8 : 16));
      end
      cfg <= 5'h08;
      repeat (6) @(posedge clk_i);
      rd(8'h10, 32'h11);
   endtask
   task automatic t_src;
      wb(1'b1, 8'h08, 32'hFF);
      for (int i = 0; i < 4; i++) begin
         {low_voltage_detect_i, loss_of_lock_i, loss_of_clock_i, watchdog_reset_i} <= 4'h1 << i;
         repeat (30) @(posedge clk_i);
         chk(reset_out_n_o, 0);
         {low_voltage_detect_i, loss_of_lock_i, loss_of_clock_i, watchdog_reset_i} <= 4'h0;
         wrel;
         rd(8'h04, 32'h08 << i);
      end
      rd(8'h08, 32'hF8);
      chk(irq_o, 0);
      wb(1'b1, 8'h0C, 32'h08);
      chk(irq_o, 1);
      wb(1'b1, 8'h08, 32'h08);
      chk(irq_o, 0);
      rd(8'h08, 32'hF0);
   endtask
   // Counts output toggles over 16 cycles against the selected source rate.
   task automatic t_clk(input int e);
      int ns, nx;
      logic ps, px;
      ns = 0;
      nx = 0;
      ps = system_clock_out_o;
      px = osc_out_strap_o;
      repeat (16) begin
         @(posedge clk_i);
         ns += (system_clock_out_o != ps);
         nx += (osc_out_strap_o != px);
         ps = system_clock_out_o;
         px = osc_out_strap_o;
      end
      chk(ns, e);
      chk(nx, 16);
   endtask
   // Clock enable low freezes the stretch, which resumes once it returns.
   task automatic t_ce;
      wb(1'b1, 8'h00, 32'h01);
      ce_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      chk(reset_out_n_o, 0);
      ce_i <= 1'b1;
      wrel;
      rd(8'h04, 32'h04);
   endtask
   // Main sequence after a four-cycle reset.
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_por;
      t_pin;
      t_modes;
      t_src;
      t_ce;
      test_done;
   end
   // Cuts a hang short.
   initial begin
      #100000;
      n_fail++;
      test_done;
   end
endmodule // rcbm_reset_boot_tb
